// >>> logic/fcd_pkg.sv
// Constants, offsets and carrier types for the configuration command decoder.
// How it works
// - Feature command EFh takes subcommand from feature, value from sector count.
// - Narrow mode 01h moves data on D[7:0], keeps wide-cycle indicator off; 81h restores.
// - 02h enables write cache; 82h disables and flushes before completion.
// - 03h takes sector count as transfer type (upper 5) and mode (low 3).
// - Exactly one PIO mode and one multiword DMA mode are always held.
// - 05h enables, 85h disables advanced power management flag.
// - 09h enables, 89h disables extended power operations flag.
// - 0Ah permits, 8Ah forbids power-level-1 commands; flag is kept.
// - 44h selects device-specific long check bytes; BBh selects four bytes.
// - 55h turns read look-ahead off; AAh turns it back on.
// - 66h keeps settings across soft reset; CCh restores default reload.
// - Subcommands 69h and 96h are accepted and change nothing.
// - Subcommand 97h is accepted for compatibility.
// - 9Ah records the host current-source capability from sector count.
// - Opcode C6h sets multi-sector block count from sector count.
// - Opcodes 99h or E6h enter sleep; only drive-select bit matters.
// - Opcodes 96h or E2h enter standby; only drive-select bit matters.
// - Extended error goes to its own register, error register shows 04h; unknown command reports 20h.
package fcd_pkg;

  localparam logic [7:0] A_FEAT_ERR = 8'h00;
  localparam logic [7:0] A_SECCNT = 8'h04;
  localparam logic [7:0] A_DRVHEAD = 8'h08;
  localparam logic [7:0] A_CMD_STAT = 8'h0C;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_XFER = 8'h14;
  localparam logic [7:0] A_MULT = 8'h18;
  localparam logic [7:0] A_CURSRC = 8'h1C;
  localparam logic [7:0] A_EXTERR = 8'h20;
  localparam logic [7:0] A_SRST = 8'h24;

  localparam logic [7:0] OP_FEAT = 8'hEF;
  localparam logic [7:0] OP_MULT = 8'hC6;
  localparam logic [7:0] OP_SLEEP_A = 8'h99;
  localparam logic [7:0] OP_SLEEP_B = 8'hE6;
  localparam logic [7:0] OP_STBY_A = 8'h96;
  localparam logic [7:0] OP_STBY_B = 8'hE2;

  localparam logic [7:0] SF_NARROW_ON = 8'h01;
  localparam logic [7:0] SF_NARROW_OFF = 8'h81;
  localparam logic [7:0] SF_WCACHE_ON = 8'h02;
  localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_EXTPWR_ON = 8'h09;
  localparam logic [7:0] SF_EXTPWR_OFF = 8'h89;
  localparam logic [7:0] SF_PL1_ON = 8'h0A;
  localparam logic [7:0] SF_PL1_OFF = 8'h8A;
  localparam logic [7:0] SF_LONG_VENDOR = 8'h44;
  localparam logic [7:0] SF_LONG_FOUR = 8'hBB;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_RLA_ON = 8'hAA;
  localparam logic [7:0] SF_KEEP_ON = 8'h66;
  localparam logic [7:0] SF_KEEP_OFF = 8'hCC;
  localparam logic [7:0] SF_NOP_A = 8'h69;
  localparam logic [7:0] SF_NOP_B = 8'h96;
  localparam logic [7:0] SF_LEGACY = 8'h97;
  localparam logic [7:0] SF_CURSRC = 8'h9A;

  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_MWDMA = 5'h04;

  localparam logic [7:0] EXT_NONE = 8'h00;
  localparam logic [7:0] EXT_ABORTED = 8'h1F;
  localparam logic [7:0] EXT_INVALID = 8'h20;
  localparam logic [7:0] ERR_ABRT = 8'h04;

  localparam int DRV_BIT = 4;
  localparam int STAT_BSY = 7;
  localparam int STAT_RDY = 6;
  localparam int STAT_ERR = 0;
  localparam int SRST_BIT = 0;

  typedef struct packed {
    logic narrow;
    logic wcache;
    logic apm;
    logic extpwr;
    logic pl1_ok;
    logic long_vendor;
    logic rla;
    logic keep_cfg;
  } fcd_cfg_s;

  typedef struct packed {
    logic known;
    logic flush;
    logic set_pio;
    logic set_dma;
    logic set_cursrc;
    fcd_cfg_s cfg;
  } fcd_act_s;

  localparam fcd_cfg_s CFG_RESET = 8'h4A;
  localparam logic [2:0] PIO_RESET = 3'h0;
  localparam logic [2:0] DMA_RESET = 3'h0;
  localparam logic [7:0] MULT_RESET = 8'h00;
  localparam logic [7:0] CURSRC_RESET = 8'h00;

endpackage

// >>> logic/fcd_feature_decode.sv
// Subcommand decoder for the feature-setting command.
`timescale 1ns/1ns
module fcd_feature_decode
  import fcd_pkg::*;
(
  input wire logic [7:0] feat, // Subcommand code.
  input wire logic [7:0] seccnt, // Configuration value.
  input wire fcd_pkg::fcd_cfg_s cur, // Settings now in force.
  output fcd_pkg::fcd_act_s act // Decoded action.
);
  import fcd_pkg::*;

  always_comb
  begin
    act.known = 1'b1;
    act.flush = 1'b0;
    act.set_pio = 1'b0;
    act.set_dma = 1'b0;
    act.set_cursrc = 1'b0;
    act.cfg = cur;
    unique case (feat)
      SF_NARROW_ON: act.cfg.narrow = 1'b1;
      SF_NARROW_OFF: act.cfg.narrow = 1'b0;
      SF_WCACHE_ON: act.cfg.wcache = 1'b1;
      SF_WCACHE_OFF:
      begin
        act.cfg.wcache = 1'b0;
        act.flush = 1'b1;
      end
      SF_XFER:
      begin
        unique case (seccnt[7:3])
          XT_PIO_DEF, XT_PIO_FC: act.set_pio = 1'b1;
          XT_MWDMA: act.set_dma = 1'b1;
          default: act.known = 1'b0;
        endcase
      end
      SF_APM_ON: act.cfg.apm = 1'b1;
      SF_APM_OFF: act.cfg.apm = 1'b0;
      SF_EXTPWR_ON: act.cfg.extpwr = 1'b1;
      SF_EXTPWR_OFF: act.cfg.extpwr = 1'b0;
      SF_PL1_ON: act.cfg.pl1_ok = 1'b1;
      SF_PL1_OFF: act.cfg.pl1_ok = 1'b0;
      SF_LONG_VENDOR: act.cfg.long_vendor = 1'b1;
      SF_LONG_FOUR: act.cfg.long_vendor = 1'b0;
      SF_RLA_OFF: act.cfg.rla = 1'b0;
      SF_RLA_ON: act.cfg.rla = 1'b1;
      SF_KEEP_ON: act.cfg.keep_cfg = 1'b1;
      SF_KEEP_OFF: act.cfg.keep_cfg = 1'b0;
      SF_NOP_A, SF_NOP_B: act.known = 1'b1;
      SF_LEGACY: act.known = 1'b1;
      SF_CURSRC: act.set_cursrc = 1'b1;
      default: act.known = 1'b0;
    endcase
  end

endmodule

// >>> logic/fcd_top.sv
// Task-file command decoder for configuration, block-count and power commands.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module fcd_top
  import fcd_pkg::*;
(
  input wire logic hclk, // Bus clock, 50 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Response, always OKAY.
  input wire logic drive_id, // Drive number strap pin.
  input wire logic data_reg_sel, // Host is accessing the data register.
  input wire logic flush_done, // Cache flush to storage finished.
  output logic wide_cycle_indicator_n, // Low marks a 16-bit data cycle.
  output logic flush_req, // Cache flush in progress.
  output logic narrow_bus, // Data moves on low byte lanes only.
  output logic sleep_state, // Device is asleep.
  output logic standby_state, // Device is in standby.
  output logic busy // Command in progress.
);
  import fcd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} fcd_state_e;

  function automatic logic op_known(input logic [7:0] op);
    op_known = (op == OP_FEAT) || (op == OP_MULT) || (op == OP_SLEEP_A) || (op == OP_SLEEP_B)
      || (op == OP_STBY_A) || (op == OP_STBY_B);
  endfunction

  // Pin inputs pass two flip-flops; only the second stage is read.
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {flush_done, data_reg_sel, drive_id};
      sync2_reg <= sync1_reg;
    end
  end
  wire drive_id_s = sync2_reg[0];
  wire data_sel_s = sync2_reg[1];
  wire flush_done_s = sync2_reg[2];

  // Bus slave: writes finish with no wait, reads take one wait state so that
  // a write just before is already visible.
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] rd_addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  wire addr_ok = hsel & htrans[1] & hready;
  wire [31:0] rd_data;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_ok & hwrite;
      rd_pend_reg <= addr_ok & ~hwrite;
      if (addr_ok)
      begin
        wr_addr_reg <= haddr[7:0];
        rd_addr_reg <= haddr[7:0];
      end
      hreadyout_reg <= ~(addr_ok & ~hwrite);
      if (rd_pend_reg)
        hrdata_reg <= rd_data;
    end
  end
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;

  // Task file and settings.
  fcd_state_e state_reg;
  fcd_state_e state_next;
  logic [7:0] feat_reg;
  logic [7:0] seccnt_reg;
  logic [7:0] drvhead_reg;
  logic [7:0] cmd_reg;
  logic [7:0] err_reg;
  logic [7:0] exterr_reg;
  fcd_cfg_s cfg_reg;
  logic [2:0] pio_reg;
  logic [2:0] dma_reg;
  logic [7:0] mult_reg;
  logic [7:0] cursrc_reg;
  logic sleep_reg;
  logic standby_reg;
  logic wide_n_reg;
  logic flush_req_reg;
  logic busy_reg;
  logic narrow_reg;
  fcd_act_s act;

  fcd_feature_decode u_decode (
    .feat(feat_reg),
    .seccnt(seccnt_reg),
    .cur(cfg_reg),
    .act(act)
  );

  wire idle = (state_reg == ST_IDLE);
  wire wr_any = wr_pend_reg;
  wire we_feat = wr_any & idle & (wr_addr_reg == A_FEAT_ERR);
  wire we_seccnt = wr_any & idle & (wr_addr_reg == A_SECCNT);
  wire we_drvhead = wr_any & idle & (wr_addr_reg == A_DRVHEAD);
  // Only a reset wakes a sleeping device; commands are dropped while asleep.
  wire we_cmd = wr_any & idle & ~sleep_reg & (wr_addr_reg == A_CMD_STAT);
  wire srst = wr_any & (wr_addr_reg == A_SRST) & hwdata[SRST_BIT];

  wire st_exec = (state_reg == ST_EXEC);
  wire drive_match = (drvhead_reg[DRV_BIT] == drive_id_s);
  wire exec_ok = st_exec & drive_match;
  wire is_feat = exec_ok & (cmd_reg == OP_FEAT);
  wire feat_ok = is_feat & act.known;
  wire feat_bad = is_feat & ~act.known;
  wire is_mult = exec_ok & (cmd_reg == OP_MULT);
  wire is_sleep = exec_ok & ((cmd_reg == OP_SLEEP_A) | (cmd_reg == OP_SLEEP_B));
  wire is_stby = exec_ok & ((cmd_reg == OP_STBY_A) | (cmd_reg == OP_STBY_B));
  wire is_unk = exec_ok & ~op_known(cmd_reg);
  wire reload = srst & ~cfg_reg.keep_cfg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: if (we_cmd) state_next = ST_EXEC;
      ST_EXEC: state_next = (feat_ok & act.flush) ? ST_FLUSH : ST_IDLE;
      ST_FLUSH: if (flush_done_s) state_next = ST_IDLE;
    endcase
    if (srst)
      state_next = ST_IDLE;
  end

  wire fcd_cfg_s cfg_next = reload ? CFG_RESET : (feat_ok ? act.cfg : cfg_reg);
  wire [2:0] pio_next = reload ? PIO_RESET : ((feat_ok & act.set_pio) ? seccnt_reg[2:0] : pio_reg);
  wire [2:0] dma_next = reload ? DMA_RESET : ((feat_ok & act.set_dma) ? seccnt_reg[2:0] : dma_reg);
  wire [7:0] cursrc_next = (feat_ok & act.set_cursrc) ? seccnt_reg : cursrc_reg;
  wire [7:0] mult_next = is_mult ? seccnt_reg : mult_reg;
  wire fail = feat_bad | is_unk;
  wire [7:0] err_next = srst ? 8'h00 : (exec_ok ? (fail ? ERR_ABRT : 8'h00) : err_reg);
  wire [7:0] ext_sel = is_unk ? EXT_INVALID : (feat_bad ? EXT_ABORTED : EXT_NONE);
  wire [7:0] exterr_next = srst ? EXT_NONE : (exec_ok ? ext_sel : exterr_reg);
  wire sleep_next = ~srst & (is_sleep | (sleep_reg & ~exec_ok));
  wire standby_next = ~srst & (is_stby | (standby_reg & ~exec_ok));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      feat_reg <= 8'h00;
      seccnt_reg <= 8'h00;
      drvhead_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end
    else
    begin
      if (we_feat)
        feat_reg <= hwdata[7:0];
      if (we_seccnt)
        seccnt_reg <= hwdata[7:0];
      if (we_drvhead)
        drvhead_reg <= hwdata[7:0];
      if (we_cmd)
        cmd_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      cfg_reg <= CFG_RESET;
      pio_reg <= PIO_RESET;
      dma_reg <= DMA_RESET;
      mult_reg <= MULT_RESET;
      cursrc_reg <= CURSRC_RESET;
      err_reg <= 8'h00;
      exterr_reg <= EXT_NONE;
      sleep_reg <= 1'b0;
      standby_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      pio_reg <= pio_next;
      dma_reg <= dma_next;
      mult_reg <= mult_next;
      cursrc_reg <= cursrc_next;
      err_reg <= err_next;
      exterr_reg <= exterr_next;
      sleep_reg <= sleep_next;
      standby_reg <= standby_next;
    end
  end

  // Pin outputs, each from its own flip-flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wide_n_reg <= 1'b1;
      flush_req_reg <= 1'b0;
      busy_reg <= 1'b0;
      narrow_reg <= 1'b0;
    end
    else
    begin
      wide_n_reg <= ~(data_sel_s & ~cfg_reg.narrow);
      flush_req_reg <= (state_next == ST_FLUSH);
      busy_reg <= (state_next != ST_IDLE);
      narrow_reg <= cfg_next.narrow;
    end
  end
  assign wide_cycle_indicator_n = wide_n_reg;
  assign flush_req = flush_req_reg;
  assign busy = busy_reg;
  assign narrow_bus = narrow_reg;
  assign sleep_state = sleep_reg;
  assign standby_state = standby_reg;

  wire [7:0] status = {~idle, idle, 5'h00, (err_reg != 8'h00)};
  assign rd_data =
    (rd_addr_reg == A_FEAT_ERR) ? {24'h00_0000, err_reg} :
    (rd_addr_reg == A_SECCNT) ? {24'h00_0000, seccnt_reg} :
    (rd_addr_reg == A_DRVHEAD) ? {24'h00_0000, drvhead_reg} :
    (rd_addr_reg == A_CMD_STAT) ? {24'h00_0000, status} :
    (rd_addr_reg == A_CFG) ? {24'h00_0000, cfg_reg} :
    (rd_addr_reg == A_XFER) ? {21'h00_0000, dma_reg, 5'h00, pio_reg} :
    (rd_addr_reg == A_MULT) ? {24'h00_0000, mult_reg} :
    (rd_addr_reg == A_CURSRC) ? {24'h00_0000, cursrc_reg} :
    (rd_addr_reg == A_EXTERR) ? {24'h00_0000, exterr_reg} : 32'h0000_0000;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_NARROW_LANES: assert property (
    (cfg_reg.narrow && cfg_next.narrow) ##1 cfg_reg.narrow |=> wide_cycle_indicator_n)
    else $error("wide cycle indicated in narrow mode");

  AST_FLUSH_BEFORE_DONE: assert property (
    (state_reg == ST_FLUSH && !flush_done_s && !srst) |=> busy_reg && flush_req_reg)
    else $error("completion before cache flush finished");

  AST_FLUSH_ENTRY: assert property (
    (is_feat && feat_reg == SF_WCACHE_OFF && !srst) |=> state_reg == ST_FLUSH && !cfg_reg.wcache)
    else $error("write cache disable did not start a flush");

  AST_DMA_MODE: assert property (
    (is_feat && feat_reg == SF_XFER && seccnt_reg[7:3] == XT_MWDMA && !srst)
    |=> dma_reg == $past(seccnt_reg[2:0]) && $stable(pio_reg))
    else $error("multiword DMA mode not taken from sector count");

  AST_ONE_PIO: assert property (
    !(feat_ok && act.set_pio) && !reload |=> $stable(pio_reg))
    else $error("PIO mode changed without a transfer-mode command");

  AST_APM_OFF: assert property (
    (is_feat && feat_reg == SF_APM_OFF && !srst) |=> !cfg_reg.apm ##1 !cfg_reg.apm)
    else $error("power management flag not cleared");

  AST_SLEEP: assert property (
    is_sleep && !srst |=> sleep_state && !standby_state)
    else $error("sleep opcode did not enter sleep");

  AST_STANDBY: assert property (
    is_stby && !srst |=> standby_state && !sleep_state)
    else $error("standby opcode did not enter standby");

  AST_INVALID_CODE: assert property (
    is_unk && !srst |=> exterr_reg == EXT_INVALID && err_reg == ERR_ABRT)
    else $error("unknown command not reported as invalid");

  AST_ABORT_KEEPS: assert property (
    feat_bad && !srst |=> $stable(cfg_reg) && $stable(pio_reg) && $stable(dma_reg) && err_reg == ERR_ABRT)
    else $error("aborted subcommand changed a setting");

  AST_MULT_COUNT: assert property (
    is_mult && !srst |=> mult_reg == $past(seccnt_reg))
    else $error("block count not taken from sector count");

endmodule

// >>> sim/fcd_host_model.sv
// Host model: AHB-Lite master for the task-file registers plus a cache flush responder.
`timescale 1ns/1ns
module fcd_host_model
(
  input wire logic hclk, // Bus clock.
  input wire logic hready, // Bus ready.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic flush_req, // Flush in progress.
  output logic hsel, // Slave select.
  output logic [31:0] haddr, // Byte address.
  output logic [1:0] htrans, // Transfer type.
  output logic hwrite, // Write when high.
  output logic [2:0] hsize, // Transfer size.
  output logic [31:0] hwdata, // Write data.
  output logic flush_done // Flush finished.
);
  int flush_delay = 0;
  int fcnt = 0;

  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    flush_done = 1'b0;
  end

  // The storage side answers a flush flush_delay+1 cycles after flush_req rises, so both prompt and slow cases occur.
  always @(posedge hclk)
  begin
    if (flush_req !== 1'b1)
    begin
      fcnt <= 0;
      flush_done <= 1'b0;
    end
    else if (fcnt >= flush_delay)
      flush_done <= 1'b1;
    else
      fcnt <= fcnt + 1;
  end

  // One single word transfer; data is returned from the edge that ends the data phase.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // A released data bus must not keep showing the last word.
    hwdata <= ~wd;
  endtask
endmodule

// >>> sim/feature_config_cmd_decoder_bench.sv
// Self-checking bench for the configuration, block-count and power command decoder.
`timescale 1ns/1ns
module feature_config_cmd_decoder_bench;
  import fcd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic drive_id = 1'b0;
  logic data_reg_sel = 1'b0;
  logic hsel, hwrite, hready, hresp, flush_done;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic wide_cycle_indicator_n, flush_req, narrow_bus, sleep_state, standby_state, busy;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] flag_tab [18] = '{16'h01CA, 16'h814A, 16'h056A, 16'h097A, 16'h447E, 16'h557C, 16'h8A74,
    16'h6974, 16'h9674, 16'h9774, 16'h8554, 16'h8944, 16'hBB40, 16'hAA42, 16'h0A4A, 16'h664B, 16'hCC4A, 16'h024A};

  always #10 hclk = ~hclk;

  fcd_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .drive_id, .data_reg_sel, .flush_done, .wide_cycle_indicator_n,
    .flush_req, .narrow_bus, .sleep_state, .standby_state, .busy);

  fcd_host_model host_u (.hclk, .hready, .hrdata, .flush_req, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .flush_done);

  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fails = fails + 1;
      $display("Error at %0t: run did not finish", $time);
      give_verdict;
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d}, rv);
  endtask

  task chk_reg(input logic [7:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, 32'h0, rv);
    checked++;
    if (rv !== exp)
    begin
      fails++;
      $display("Error at %0t: register %h read %h expected %h", $time, a, rv, exp);
    end
  endtask

  task chk_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: pin level %b expected %b", $time, got, exp);
    end
  endtask

  task issue(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] sc, input logic drv);
    wr(A_FEAT_ERR, ft);
    wr(A_SECCNT, sc);
    wr(A_DRVHEAD, {3'h0, drv, 4'h0});
    wr(A_CMD_STAT, op);
  endtask

  task wait_idle;
    int n;
    n = 0;
    rv = 32'h80;
    while (rv[STAT_BSY] !== 1'b0 && n < 300)
    begin
      host_u.xfer(1'b0, A_CMD_STAT, 32'h0, rv);
      n++;
    end
    if (rv[STAT_BSY] !== 1'b0)
    begin
      fails++;
      $display("Error at %0t: device stayed busy", $time);
    end
  endtask

  task cmd(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] sc, input logic drv);
    issue(op, ft, sc, drv);
    wait_idle;
  endtask

  task t_reset;
    chk_reg(A_CFG, 32'h4A);
    chk_reg(A_XFER, 32'h0);
    chk_reg(A_MULT, 32'h0);
    chk_pin(narrow_bus, 1'b0);
    chk_pin(wide_cycle_indicator_n, 1'b1);
    chk_pin(hresp, 1'b0);
    $display("test reset done");
  endtask

  task t_flags;
    foreach (flag_tab[i])
    begin
      cmd(OP_FEAT, flag_tab[i][15:8], 8'h00, 1'b0);
      chk_reg(A_CFG, {24'h0, flag_tab[i][7:0]});
    end
    $display("test flags done");
  endtask

  task t_flush;
    int n;
    host_u.flush_delay = 12;
    issue(OP_FEAT, SF_WCACHE_OFF, 8'h00, 1'b0);
    for (n = 0; n < 8 && flush_req !== 1'b1; n++)
      @(posedge hclk);
    chk_pin(busy, 1'b1);
    repeat (6) @(posedge hclk);
    chk_pin(flush_req, 1'b1);
    chk_pin(busy, 1'b1);
    // A task-file write while the flush runs must be dropped.
    wr(A_SECCNT, 8'h55);
    wait_idle;
    chk_reg(A_CFG, 32'h0A);
    chk_reg(A_SECCNT, 32'h00);
    host_u.flush_delay = 0;
    cmd(OP_FEAT, SF_WCACHE_ON, 8'h00, 1'b0);
    cmd(OP_FEAT, SF_WCACHE_OFF, 8'h00, 1'b0);
    chk_reg(A_CFG, 32'h0A);
    cmd(OP_FEAT, SF_WCACHE_ON, 8'h00, 1'b0);
    chk_reg(A_CFG, 32'h4A);
    $display("test flush done");
  endtask

  task t_narrow;
    @(posedge hclk);
    data_reg_sel <= 1'b1;
    repeat (8) @(posedge hclk);
    chk_pin(wide_cycle_indicator_n, 1'b0);
    cmd(OP_FEAT, SF_NARROW_ON, 8'h00, 1'b0);
    repeat (8) @(posedge hclk);
    chk_pin(narrow_bus, 1'b1);
    chk_pin(wide_cycle_indicator_n, 1'b1);
    cmd(OP_FEAT, SF_NARROW_OFF, 8'h00, 1'b0);
    repeat (8) @(posedge hclk);
    chk_pin(wide_cycle_indicator_n, 1'b0);
    data_reg_sel <= 1'b0;
    repeat (8) @(posedge hclk);
    chk_pin(wide_cycle_indicator_n, 1'b1);
    $display("test narrow done");
  endtask

  task t_xfer;
    cmd(OP_FEAT, SF_XFER, {XT_PIO_FC, 3'h5}, 1'b0);
    chk_reg(A_XFER, 32'h005);
    cmd(OP_FEAT, SF_XFER, {XT_MWDMA, 3'h2}, 1'b0);
    chk_reg(A_XFER, 32'h205);
    cmd(OP_FEAT, SF_XFER, {XT_PIO_DEF, 3'h1}, 1'b0);
    chk_reg(A_XFER, 32'h201);
    cmd(OP_FEAT, SF_XFER, {5'h02, 3'h7}, 1'b0);
    chk_reg(A_XFER, 32'h201);
    chk_reg(A_EXTERR, 32'h1F);
    $display("test transfer mode done");
  endtask

  task t_abort;
    cmd(OP_FEAT, 8'h77, 8'h00, 1'b0);
    chk_reg(A_FEAT_ERR, 32'h04);
    chk_reg(A_EXTERR, 32'h1F);
    chk_reg(A_CFG, 32'h4A);
    cmd(8'h11, 8'h00, 8'h00, 1'b0);
    chk_reg(A_EXTERR, 32'h20);
    chk_reg(A_CMD_STAT, 32'h41);
    cmd(OP_FEAT, SF_NOP_A, 8'h00, 1'b0);
    chk_reg(A_FEAT_ERR, 32'h00);
    $display("test abort done");
  endtask

  task t_mult;
    cmd(OP_MULT, 8'h00, 8'h10, 1'b0);
    chk_reg(A_MULT, 32'h10);
    cmd(OP_FEAT, SF_CURSRC, 8'h03, 1'b0);
    chk_reg(A_CURSRC, 32'h03);
    $display("test block count done");
  endtask

  task t_power;
    cmd(OP_STBY_B, 8'h00, 8'h00, 1'b1);
    chk_pin(standby_state, 1'b0);
    @(posedge hclk);
    drive_id <= 1'b1;
    repeat (3) @(posedge hclk);
    cmd(OP_STBY_B, 8'h00, 8'h00, 1'b1);
    chk_pin(standby_state, 1'b1);
    chk_reg(A_DRVHEAD, 32'h10);
    @(posedge hclk);
    drive_id <= 1'b0;
    repeat (3) @(posedge hclk);
    cmd(OP_MULT, 8'h00, 8'h10, 1'b0);
    chk_pin(standby_state, 1'b0);
    cmd(OP_STBY_B, 8'h00, 8'h00, 1'b0);
    chk_pin(standby_state, 1'b1);
    cmd(OP_MULT, 8'h00, 8'h10, 1'b0);
    chk_pin(standby_state, 1'b0);
    cmd(OP_STBY_A, 8'hFF, 8'hFF, 1'b0);
    chk_pin(standby_state, 1'b1);
    cmd(OP_SLEEP_A, 8'h00, 8'h00, 1'b0);
    chk_pin(sleep_state, 1'b1);
    // A sleeping device drops commands until it is reset.
    cmd(OP_STBY_B, 8'h00, 8'h00, 1'b0);
    chk_pin(standby_state, 1'b0);
    chk_pin(sleep_state, 1'b1);
    wr(A_SRST, 8'h01);
    cmd(OP_SLEEP_B, 8'h00, 8'h00, 1'b1);
    chk_pin(sleep_state, 1'b0);
    cmd(OP_SLEEP_B, 8'hFF, 8'hFF, 1'b0);
    chk_pin(sleep_state, 1'b1);
    wr(A_SRST, 8'h01);
    cmd(OP_FEAT, SF_KEEP_ON, 8'h00, 1'b0);
    cmd(OP_FEAT, SF_RLA_OFF, 8'h00, 1'b0);
    wr(A_SRST, 8'h01);
    chk_reg(A_CFG, 32'h49);
    chk_reg(A_MULT, 32'h10);
    cmd(OP_FEAT, SF_KEEP_OFF, 8'h00, 1'b0);
    wr(A_SRST, 8'h01);
    chk_reg(A_CFG, 32'h4A);
    $display("test power done");
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_flags;
    t_flush;
    t_narrow;
    t_xfer;
    t_abort;
    t_mult;
    t_power;
    give_verdict;
  end
endmodule
